// ---- rtl/led_dim_params.svh ----
// timing, geometry and table constants for the led burst dimming controller
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH
// ************************************************************
// clock and switching period
// ************************************************************
`define CLK_MHZ          100
`define SW_PERIOD_NS     4000
`define SW_CYCLES        (`SW_PERIOD_NS * `CLK_MHZ / 1000)
`define CMP_PCT_1        20
`define CMP_PCT_2        40
`define CMP_PCT_3        60
`define CMP_PCT_4        80
// ************************************************************
// burst, flash, button and indicator timing
// ************************************************************
`define BURST_PERIOD_US  2500
`define FLASH_PERIOD_MS  100
`define FLASH_ON_MS      20
`define LONG_PRESS_MS    1000
`define DEBOUNCE_MS      10
`define SEQ_STEP_MS      250
`define DITHER_LEN       8
`define SOFT_BURSTS      250
// ************************************************************
// brightness and threshold ramp
// ************************************************************
`define LEVEL_W          7
`define LEVEL_MAX        7'h7f
`define THR_W            12
`define RAMP_BASE        12'h200
`define RAMP_STEP        12'h040
`endif

// ---- rtl/led_dim_pkg.sv ----
// types shared by the led burst dimming controller
package led_dim_pkg;
  // operating modes, gray coded in the order off, auto, flash, manual
  typedef enum logic [1:0]
  {
    mode_off    = 2'b00,
    mode_auto   = 2'b01,
    mode_flash  = 2'b11,
    mode_manual = 2'b10
  } mode_t;
endpackage

// ---- rtl/dither_rom.sv ----
// dither pattern table: one 8-bit pattern per fine brightness step
`timescale 1ns/100ps
module dither_rom
  import led_dim_pkg::*;
(
  // clock
  input  wire logic       clk,
  input  wire logic       nrst,
  // read port
  input  wire logic [2:0] addr,
  output logic      [7:0] data
);
  logic [7:0] table_val;

  // more set bits means more extra pulses in the 8-burst group
  always_comb
  begin
    unique case (addr)
      3'h0: table_val = 8'h00;
      3'h1: table_val = 8'h80;
      3'h2: table_val = 8'h88;
      3'h3: table_val = 8'ha4;
      3'h4: table_val = 8'haa;
      3'h5: table_val = 8'hd6;
      3'h6: table_val = 8'hee;
      3'h7: table_val = 8'hfe;
    endcase
  end

  // registered read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      data <= 8'h00;
    else
      data <= table_val;
  end
endmodule

// ---- rtl/led_burst_dimming_controller.sv ----
// burst mode current-controlled led dimmer with dither, ramp, soft start and button modes
`timescale 1ns/100ps
`include "led_dim_params.svh"
module led_burst_dimming_controller
  import led_dim_pkg::*;
#(
  parameter int BURST_CYCLES = `BURST_PERIOD_US * `CLK_MHZ,
  parameter int FLASH_CYCLES = `FLASH_PERIOD_MS * 1000 * `CLK_MHZ,
  parameter int FLASH_ON     = `FLASH_ON_MS * 1000 * `CLK_MHZ,
  parameter int LONG_CYCLES  = `LONG_PRESS_MS * 1000 * `CLK_MHZ,
  parameter int DEB_CYCLES   = `DEBOUNCE_MS * 1000 * `CLK_MHZ,
  parameter int SEQ_CYCLES   = `SEQ_STEP_MS * 1000 * `CLK_MHZ
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // pins from outside
  input  wire logic              user_button,
  input  wire logic              current_comparator,
  // power stage
  output logic                   led_switch,
  output logic [`THR_W-1:0]      dac_threshold,
  output logic                   threshold_load,
  // indicators
  output logic                   increase_indicator,
  output logic                   decrease_indicator,
  output logic                   flash_indicator_a,
  output logic                   flash_indicator_b
);
  localparam logic [8:0] SW_LAST   = 9'(`SW_CYCLES - 1);
  localparam logic [8:0] RAMP_AT_1 = 9'(`SW_CYCLES * `CMP_PCT_1 / 100);
  localparam logic [8:0] RAMP_AT_2 = 9'(`SW_CYCLES * `CMP_PCT_2 / 100);
  localparam logic [8:0] RAMP_AT_3 = 9'(`SW_CYCLES * `CMP_PCT_3 / 100);
  localparam logic [8:0] RAMP_AT_4 = 9'(`SW_CYCLES * `CMP_PCT_4 / 100);
  // spacing of two ramp steps, used as a plain delay by the checks
  localparam int         RAMP_GAP  = `SW_CYCLES * (`CMP_PCT_2 - `CMP_PCT_1) / 100;

  mode_t             mode;
  logic [1:0]        btn_sync, cmp_sync;
  logic              btn_stable, long_done, short_press, long_press;
  logic [31:0]       deb_cnt, hold_cnt, flash_cnt, seq_cnt;
  logic [8:0]        sw_cnt;
  logic [31:0]       burst_cnt;
  logic              period_evt, burst_evt, seq_end, active;
  logic [2:0]        phase, ramp_idx, ramp_now;
  logic [7:0]        pattern, soft_cnt;
  logic [4:0]        pulses_left, next_pulses;
  logic [`LEVEL_W-1:0] level;
  logic              dir_up, blink;
  logic [3:0]        ring;
  logic [19:0]       scaled;

  // ************************************************************
  // input synchronisers and button classification
  // ************************************************************
  // both inputs are asynchronous to clk, so two flops before any use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      btn_sync <= 2'b00;
      cmp_sync <= 2'b00;
    end
    else
    begin
      btn_sync <= {btn_sync[0], user_button};
      cmp_sync <= {cmp_sync[0], current_comparator};
    end
  end

  // level must hold for the debounce time before it is believed
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      deb_cnt    <= '0;
      btn_stable <= 1'b0;
    end
    else if (btn_sync[1] == btn_stable)
      deb_cnt <= '0;
    else if (deb_cnt >= 32'(DEB_CYCLES - 1))
    begin
      deb_cnt    <= '0;
      btn_stable <= btn_sync[1];
    end
    else
      deb_cnt <= deb_cnt + 32'h1;
  end

  // long press fires while still held, so manual entry does not wait for release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_cnt <= '0;
      long_done <= 1'b0;
    end
    else if (!btn_stable)
    begin
      hold_cnt  <= '0;
      long_done <= 1'b0;
    end
    else if (!long_done)
    begin
      hold_cnt  <= hold_cnt + 32'h1;
      long_done <= (hold_cnt >= 32'(LONG_CYCLES - 1));
    end
  end

  assign long_press  = btn_stable && !long_done && (hold_cnt >= 32'(LONG_CYCLES - 1));
  assign short_press = !btn_stable && !long_done && (hold_cnt != '0);

  // ************************************************************
  // mode state machine
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode <= mode_off;
    else if (long_press)
      mode <= mode_manual;
    else if (short_press)
    begin
      unique case (mode)
        mode_off:    mode <= mode_auto;
        mode_auto:   mode <= mode_flash;
        mode_flash:  mode <= mode_off;
        mode_manual: mode <= mode_off;
      endcase
    end
  end

  // ************************************************************
  // switching period, compare events and burst timing
  // ************************************************************
  assign period_evt = (sw_cnt == 9'h000);
  assign burst_evt  = period_evt && (burst_cnt == '0);
  assign seq_end    = burst_evt && (phase == 3'h7);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sw_cnt <= '0;
    else
      sw_cnt <= (sw_cnt == SW_LAST) ? 9'h000 : sw_cnt + 9'h001;
  end

  // burst counter steps once per switching period: 625 periods make 2.5 ms
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      burst_cnt <= '0;
    else if (sw_cnt == SW_LAST)
      burst_cnt <= (burst_cnt >= 32'(BURST_CYCLES / `SW_CYCLES - 1)) ? '0
                   : burst_cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase <= '0;
    else if (burst_evt)
      phase <= phase + 3'h1;
  end

  // ************************************************************
  // pulse scheduling and the switch
  // ************************************************************
  assign active = (mode == mode_auto) || (mode == mode_manual)
                  || ((mode == mode_flash) && (flash_cnt < 32'(FLASH_ON)));

  dither_rom u_dither
  (
    .clk  (clk),
    .nrst (nrst),
    .addr (level[2:0]),
    .data (pattern)
  );

  // one ignition pulse per burst plus coarse steps, plus one dither pulse when the pattern bit for the phase is set
  always_comb
  begin
    next_pulses = 5'({1'b0, level[`LEVEL_W-1:3]}) + 5'({4'h0, pattern[phase]});
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pulses_left <= '0;
    else if (!active)
      pulses_left <= '0;
    else if (burst_evt)
      pulses_left <= next_pulses;
    else if (period_evt && pulses_left != '0)
      pulses_left <= pulses_left - 5'h01;
  end

  // a period event that starts a pulse wins over a comparator trip landing in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      led_switch <= 1'b0;
    else if (!active)
      led_switch <= 1'b0;
    else if (burst_evt || (period_evt && pulses_left != '0))
      led_switch <= 1'b1;
    else if (cmp_sync[1])
      led_switch <= 1'b0;
  end

  // ************************************************************
  // threshold ramp with soft start
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      soft_cnt <= '0;
    else if (!active)
      soft_cnt <= '0;
    else if (burst_evt && soft_cnt < 8'(`SOFT_BURSTS))
      soft_cnt <= soft_cnt + 8'h01;
  end

  always_comb
  begin
    // the period start always takes the foot of the ramp, never the last step
    ramp_now = period_evt ? 3'h0 : ramp_idx;
    scaled   = 20'(`RAMP_BASE + 12'(ramp_now) * `RAMP_STEP) * 20'(soft_cnt);
  end

  // one step per event; the latency of the table is a single cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ramp_idx       <= '0;
      dac_threshold  <= '0;
      threshold_load <= 1'b0;
    end
    else
    begin
      threshold_load <= 1'b0;
      if (period_evt || sw_cnt == RAMP_AT_1 || sw_cnt == RAMP_AT_2
          || sw_cnt == RAMP_AT_3 || sw_cnt == RAMP_AT_4)
      begin
        ramp_idx       <= period_evt ? 3'h1 : ramp_idx + 3'h1;
        dac_threshold  <= `THR_W'(scaled / 20'(`SOFT_BURSTS));
        threshold_load <= 1'b1;
      end
    end
  end

  // ************************************************************
  // brightness sweep
  // ************************************************************
  // sweep steps change level only at the end of an 8-burst group so patterns stay whole
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      level  <= '0;
      dir_up <= 1'b1;
    end
    else if (mode == mode_off || (mode != mode_manual && long_press))
    begin
      level  <= '0;
      dir_up <= 1'b1;
    end
    else if (mode == mode_manual && long_press)
      dir_up <= !dir_up;
    else if (mode == mode_flash)
      level  <= `LEVEL_MAX;
    else if (seq_end && dir_up && level != `LEVEL_MAX)
      level  <= level + `LEVEL_W'(1);
    else if (seq_end && !dir_up && level != '0)
      level  <= level - `LEVEL_W'(1);
    else if (seq_end && mode == mode_auto)
      dir_up <= !dir_up;
  end

  // ************************************************************
  // flash timing and indicators
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flash_cnt <= '0;
    else if (mode != mode_flash || flash_cnt >= 32'(FLASH_CYCLES - 1))
      flash_cnt <= '0;
    else
      flash_cnt <= flash_cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_cnt <= '0;
      ring    <= 4'h1;
    end
    else if (seq_cnt >= 32'(SEQ_CYCLES - 1))
    begin
      seq_cnt <= '0;
      ring    <= {ring[2:0], ring[3]};
    end
    else
      seq_cnt <= seq_cnt + 32'h1;
  end

  // blink toggles each dither group while manual dimming sits at an end stop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      blink <= 1'b0;
    else if (mode == mode_manual && seq_end
             && (dir_up ? level == `LEVEL_MAX : level == '0))
      blink <= !blink;
    else if (mode != mode_manual || long_press)
      blink <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      increase_indicator <= 1'b0;
      decrease_indicator <= 1'b0;
      flash_indicator_a  <= 1'b0;
      flash_indicator_b  <= 1'b0;
    end
    else
    begin
      increase_indicator <= (mode == mode_off) ? ring[0]
                          : (mode != mode_flash) && dir_up && !blink;
      decrease_indicator <= (mode == mode_off) ? ring[3]
                          : (mode != mode_flash) && !dir_up && !blink;
      flash_indicator_a  <= (mode == mode_off) ? ring[1]
                          : (mode == mode_flash) && active;
      flash_indicator_b  <= (mode == mode_off) ? ring[2]
                          : (mode == mode_flash) && active;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_short;
    short_press;
  endsequence
  sequence s_to_off;
    ##1 mode == mode_off;
  endsequence

  a_off_no_switch: assert property (@(posedge clk) disable iff (!nrst)
    mode == mode_off |-> ##1 !led_switch) else $error("switch driven in off");
  a_flash_short: assert property (@(posedge clk) disable iff (!nrst)
    mode == mode_flash && !long_press ##0 s_short |-> s_to_off) else $error("flash exit");
  a_manual_short: assert property (@(posedge clk) disable iff (!nrst)
    mode == mode_manual && !long_press ##0 s_short |-> s_to_off)
    else $error("manual exit");
  a_off_short: assert property (@(posedge clk) disable iff (!nrst)
    mode == mode_off && short_press && !long_press |=> mode == mode_auto)
    else $error("auto entry");
  a_long_manual: assert property (@(posedge clk) disable iff (!nrst)
    long_press |=> mode == mode_manual) else $error("manual entry");
  a_switch_hold: assert property (@(posedge clk) disable iff (!nrst)
    led_switch && !cmp_sync[1] && active |=> led_switch) else $error("switch dropped");
  a_burst_fire: assert property (@(posedge clk) disable iff (!nrst)
    burst_evt && active |=> led_switch) else $error("no ignition pulse");
  a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
    sw_cnt == RAMP_AT_1 |-> ##1 threshold_load ##RAMP_GAP threshold_load)
    else $error("ramp step missing");
  a_soft_zero: assert property (@(posedge clk) disable iff (!nrst)
    !active |=> soft_cnt == 8'h00) else $error("soft start not cleared");
endmodule

// ---- sim/led_power_stage_model.sv ----
// behavioural power stage: inductor current ramp compared against the threshold
`timescale 1ns/100ps
module led_power_stage_model
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // drive and threshold from the controller
  input  wire logic        led_switch,
  input  wire logic [11:0] dac_threshold,
  // current rise per cycle while on; zero means the current never builds
  input  wire logic [11:0] slope,
  // comparator back to the controller
  output logic             current_comparator
);
  logic [15:0] current = 16'h0000;

  initial current_comparator = 1'b0;

  // current climbs while the switch conducts and collapses once it opens;
  // the compare is strict so no current never trips even a zero threshold
  always @(posedge clk or negedge nrst)
  begin
    #1;
    if (!nrst || !led_switch)
      current = 16'h0000;
    else
      current = current + {4'h0, slope};
    current_comparator = nrst && (current > {4'h0, dac_threshold});
  end
endmodule

// ---- sim/led_burst_dimming_controller_tb.sv ----
// self-checking bench for the led burst dimming controller
`timescale 1ns/100ps
`include "led_dim_params.svh"
module led_burst_dimming_controller_tb;
  // shortened counts so the run stays brief
  localparam int BURST = 4000;
  localparam int FLASH = 2000;
  localparam int FON   = 400;
  localparam int LONGC = 500;
  localparam int DEB   = 4;
  localparam int SEQ   = 50;

  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              user_button = 1'b0;
  logic [11:0]       slope = 12'h010;
  logic              current_comparator;
  logic              led_switch;
  logic [`THR_W-1:0] dac_threshold;
  logic              threshold_load;
  logic [3:0]        ind;
  int                fails = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #5 clk = ~clk;

  led_burst_dimming_controller #(.BURST_CYCLES(BURST), .FLASH_CYCLES(FLASH),
    .FLASH_ON(FON), .LONG_CYCLES(LONGC), .DEB_CYCLES(DEB), .SEQ_CYCLES(SEQ)) DUT
  (
    .clk(clk), .nrst(nrst), .user_button(user_button),
    .current_comparator(current_comparator), .led_switch(led_switch),
    .dac_threshold(dac_threshold), .threshold_load(threshold_load),
    .increase_indicator(ind[0]), .decrease_indicator(ind[1]),
    .flash_indicator_a(ind[2]), .flash_indicator_b(ind[3])
  );

  led_power_stage_model stage
  (
    .clk(clk), .nrst(nrst), .led_switch(led_switch), .dac_threshold(dac_threshold),
    .slope(slope), .current_comparator(current_comparator)
  );

  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  // inputs move and outputs are read 2 ns after each rising edge, clear of the model
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #2;
    end
  endtask

  task automatic press(input int hold);
    user_button = 1'b1;
    tick(hold);
    user_button = 1'b0;
    tick(2 * DEB + 20);
  endtask

  task automatic count_rises(input int n, output int r);
    logic prev;
    r = 0;
    prev = led_switch;
    repeat (n)
    begin
      tick(1);
      if (led_switch === 1'b1 && prev === 1'b0)
        r++;
      prev = led_switch;
    end
  endtask

  // bounded wait, so a silent output cannot hang the run
  task automatic wait_for(input int which, output int n);
    n = 0;
    while (n < BURST + 10 && ((which == 0) ? threshold_load : led_switch) !== 1'b1)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_off;
    logic [3:0] mask;
    int         r;
    mask = 4'h0;
    check("switch after reset", led_switch, 1'b0);
    check("first ring step", ind, 4'h1);
    repeat (4 * SEQ + 10)
    begin
      tick(1);
      check("ring one lit", 32'($onehot(ind)), 1);
      mask = mask | ind;
    end
    check("ring coverage", mask, 4'hf);
    // a two-cycle glitch is shorter than the debounce and must be ignored
    user_button = 1'b1;
    tick(2);
    user_button = 1'b0;
    count_rises(BURST, r);
    check("off pulses", r, 0);
    $display("off state test done");
  endtask

  task automatic test_auto;
    int         n;
    logic [11:0] first;
    press(50);
    check("auto direction", ind[1:0], 2'b01);
    wait_for(0, n);
    first = dac_threshold;
    check("soft start low", 32'(first <= 12'h004), 1);
    repeat (5)
    begin
      tick(1);
      wait_for(0, n);
      check("load spacing", n, 79);
    end
    tick(2 * BURST);
    wait_for(0, n);
    check("soft start rising", 32'(dac_threshold > first), 1);
    // comparator trip ends the pulse after two sync stages and a register
    wait_for(1, n);
    n = 0;
    while (n < 500 && current_comparator !== 1'b1)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (n < 10 && led_switch === 1'b1)
    begin
      tick(1);
      n++;
    end
    check("trip latency", n, 3);
    // foot of the ramp at the next pulse start, top four steps later
    wait_for(1, n);
    first = dac_threshold;
    repeat (4)
    begin
      tick(1);
      wait_for(0, n);
    end
    check("ramp rises", 32'(dac_threshold > first), 1);
    $display("auto dimmer test done");
  endtask

  task automatic test_flash;
    int on_cnt;
    int rises;
    int differ;
    int stray;
    logic prev;
    on_cnt = 0;
    rises = 0;
    differ = 0;
    stray = 0;
    press(50);
    prev = ind[2];
    repeat (2 * FLASH)
    begin
      tick(1);
      on_cnt = on_cnt + int'(ind[2] === 1'b1);
      rises = rises + int'(ind[2] === 1'b1 && prev === 1'b0);
      differ = differ + int'(ind[2] !== ind[3]);
      stray = stray + int'(led_switch === 1'b1 && ind[2] !== 1'b1);
      prev = ind[2];
    end
    check("flash on time", on_cnt, 2 * FON);
    check("flash rate", rises, 2);
    check("middle pair", differ, 0);
    check("switch outside flash window", stray, 0);
    $display("flash test done");
  endtask

  task automatic test_back_off;
    int r;
    press(50);
    count_rises(BURST, r);
    check("flash to off", r, 0);
    check("ring resumed", 32'($onehot(ind)), 1);
    $display("flash exit test done");
  endtask

  task automatic test_manual;
    int r;
    int n;
    press(LONGC + 100);
    check("manual rising", ind[1:0], 2'b01);
    count_rises(BURST, r);
    check("lowest level pulses", r, 1);
    // with no current build-up the switch must never open by itself
    slope = 12'h000;
    wait_for(1, n);
    r = 0;
    repeat (600)
    begin
      tick(1);
      r = r + int'(led_switch === 1'b1);
    end
    check("held without trip", r, 600);
    slope = 12'h010;
    press(LONGC + 100);
    check("manual falling", ind[1:0], 2'b10);
    press(50);
    count_rises(BURST, r);
    check("manual to off", r, 0);
    $display("manual dimmer test done");
  endtask

  // ************************************************************
  // sequence and watchdog
  // ************************************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)  // the scenarios need roughly 41000 cycles
    begin
      fails++;
      test_done;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    #2;
    nrst = 1'b1;
    tick(1);
    test_off;
    test_auto;
    test_flash;
    test_back_off;
    test_manual;
    test_done;
  end
endmodule
